// file: core/pio_pkg.sv
package pio_pkg;

    // ========================================
    // Register word indices; byte address is four times the index
    localparam int          PIO_IDX_LSB       = 2;
    localparam int          PIO_IDX_MSB       = 17;
    localparam logic [15:0] PIO_ADDR_LATCH    = 16'hfe44;
    localparam logic [15:0] PIO_ADDR_DIR      = 16'hfe45;
    localparam logic [15:0] PIO_ADDR_FUNC     = 16'hfe46;
    localparam logic [15:0] PIO_ADDR_TEST     = 16'hfe47;
    localparam logic [15:0] PIO_ADDR_SELECT   = 16'hfe5f;
    localparam logic [15:0] PIO_ADDR_RMW      = 16'hfe60;
    localparam logic [15:0] PIO_ADDR_MODE     = 16'hfe64;

    // ========================================
    // Reset value and test register write mask
    localparam logic [7:0]  PIO_RST_REG       = 8'h00;
    localparam logic [7:0]  PIO_TEST_WMASK    = 8'h2e;

    // ========================================
    // Field positions
    localparam int          PIO_BUZ_SEL_BIT   = 3;
    localparam int          PIO_RT_OUT_BIT    = 2;
    localparam int          PIO_PIN_PWM_H     = 7;
    localparam int          PIO_PIN_PWM_L     = 6;
    localparam int          PIO_PIN_S1_CLK    = 5;
    localparam int          PIO_PIN_S1_RX     = 4;
    localparam int          PIO_PIN_S1_TX     = 3;
    localparam int          PIO_PIN_S0_CLK    = 2;
    localparam int          PIO_PIN_S0_RX     = 1;
    localparam int          PIO_PIN_S0_TX     = 0;

    // ========================================
    // Read-modify-write operations on the latch
    typedef enum logic [2:0] {
        PIO_OP_SET   = 3'b000,
        PIO_OP_CLR   = 3'b001,
        PIO_OP_INV   = 3'b010,
        PIO_OP_INC   = 3'b011,
        PIO_OP_DEC   = 3'b100
    } pio_op_t;

    // ========================================
    // AHB-Lite codes
    localparam logic [1:0]  PIO_HTRANS_NONSEQ = 2'b10;
    localparam logic [1:0]  PIO_HTRANS_SEQ    = 2'b11;
    localparam logic        PIO_HRESP_OKAY    = 1'b0;

endpackage : pio_pkg

// file: core/pio_port_one.sv
`timescale 1ns/100ps
// Function
// R01: Latch register holds output values, direction register holds pin directions.
// R02: Direction bit 1 makes the pin output, 0 makes it input.
// R03: Pull-up on only when direction is 0 and latch bit is 1.
// R04: Output 0 drives low; 1 drives high (CMOS) or floats (open drain).
// R05: Reading the data register returns the eight pin levels.
// R06: Read-modify-write operations use the latch contents, not the pins.
// R07: Function bit 0 makes an output pin carry its latch value.
// R08: Pin 7 function: high PWM, or latch XOR buzzer, per buzzer select.
// R09: Pin 6 function: low PWM XOR latch bit.
// R10: Pin 5 function: serial one clock OR latch bit.
// R11: Pins 4 and 3 function: serial one data OR latch bit.
// R12: Serial one active: receive data comes from pin 4 regardless.
// R13: Pin 2 function: serial zero clock OR latch bit.
// R14: Pins 1 and 0 function: serial zero data OR latch bit.
// R15: Serial zero active: receive data comes from pin 1 regardless.
// R16: Software writes 0 to reserved test bits 7, 6, 4 and 0.
// R17: Test register bit 2 controls the realtime counter output.
// R18: HALT or HOLD freezes outputs, directions and pull-ups until exit.
// R19: Open-drain bits enable the driver only while the output is low.
module pio_port_one (
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic [7:0]  pin_in,
    output logic      [7:0]  pin_out,
    output logic      [7:0]  pin_oe,
    output logic      [7:0]  pin_pullup,
    input  wire logic [7:0]  open_drain_sel,
    input  wire logic        halt_hold,
    input  wire logic        timer_high_pwm,
    input  wire logic        timer_low_pwm,
    input  wire logic        buzzer_signal,
    input  wire logic        serial_iface_one_clk,
    input  wire logic        serial_iface_one_txd,
    input  wire logic        serial_iface_one_active,
    input  wire logic        serial_iface_zero_clk,
    input  wire logic        serial_iface_zero_txd,
    input  wire logic        serial_iface_zero_active,
    output logic             serial_iface_one_rxd,
    output logic             serial_iface_zero_rxd,
    output logic             realtime_counter_out_ctrl
);
    import pio_pkg::*;

    // ========================================
    // Registers
    logic [7:0]  port_one_latch;
    logic [7:0]  port_one_direction;
    logic [7:0]  port_one_function_select;
    logic [7:0]  port_one_test_control;
    logic [7:0]  input_select_reg;
    logic [7:0]  rmw_operand;

    // ========================================
    // Bus phase capture
    logic        ph_valid;
    logic        ph_write;
    logic [15:0] ph_addr;
    logic [15:0] rd_idx;
    logic        ph_rmw;
    logic        wr_latch;
    logic        wr_dir;
    logic        wr_func;
    logic        wr_test;
    logic        wr_select;
    logic        wr_rmw;
    logic        rd_en;
    logic [7:0]  next_latch;
    logic [7:0]  next_pin_out;
    logic [7:0]  next_pin_oe;
    logic [7:0]  next_pullup;
    logic [7:0]  func_value;
    logic [7:0]  drive_value;
    logic [31:0] next_hrdata;

    function automatic logic hit(input logic [15:0] a, input logic [15:0] b);
        return a == b;
    endfunction : hit

    function automatic logic [7:0] rmw_apply(input logic [7:0] v, input logic [2:0] op, input logic [2:0] b);
        logic [7:0] m;
        m = 8'h01 << b;
        case (op)
            PIO_OP_SET: rmw_apply = v | m;
            PIO_OP_CLR: rmw_apply = v & ~m;
            PIO_OP_INV: rmw_apply = v ^ m;
            PIO_OP_INC: rmw_apply = v + 8'h01;
            PIO_OP_DEC: rmw_apply = v - 8'h01;
            default:    rmw_apply = v;
        endcase
    endfunction : rmw_apply

    assign rd_en  = hsel && hready && htrans[1] && !hwrite;
    assign rd_idx = haddr[PIO_IDX_MSB:PIO_IDX_LSB];

    // ========================================
    // Address phase valid flag
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ph_valid <= 1'b0;
        end else if (hready) begin
            ph_valid <= hsel && htrans[1];
        end
    end

    // ========================================
    // Address phase direction
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ph_write <= 1'b0;
        end else if (hready) begin
            ph_write <= hwrite;
        end
    end

    // ========================================
    // Address phase word index
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ph_addr <= 16'h0000;
        end else if (hready) begin
            ph_addr <= rd_idx;
        end
    end

    // ========================================
    // Write strobes
    assign ph_rmw    = ph_valid && ph_write;
    assign wr_latch  = ph_rmw && hit(ph_addr, PIO_ADDR_LATCH);
    assign wr_dir    = ph_rmw && hit(ph_addr, PIO_ADDR_DIR);
    assign wr_func   = ph_rmw && hit(ph_addr, PIO_ADDR_FUNC);
    assign wr_test   = ph_rmw && hit(ph_addr, PIO_ADDR_TEST);
    assign wr_select = ph_rmw && hit(ph_addr, PIO_ADDR_SELECT);
    assign wr_rmw    = ph_rmw && hit(ph_addr, PIO_ADDR_RMW);

    // ========================================
    // Zero wait states
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            hreadyout <= 1'b1;
        end else begin
            hreadyout <= 1'b1;
        end
    end

    // ========================================
    // Response always OKAY
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            hresp <= PIO_HRESP_OKAY;
        end else begin
            hresp <= PIO_HRESP_OKAY;
        end
    end

    // ========================================
    // Register writes
    always_comb begin
        next_latch = port_one_latch;
        if (wr_latch) begin
            next_latch = hwdata[7:0];
        end else if (wr_rmw) begin
            next_latch = rmw_apply(port_one_latch, hwdata[2:0], hwdata[6:4]); // R06
        end
    end

    // ========================================
    // Latch register
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            port_one_latch <= PIO_RST_REG;
        end else begin
            port_one_latch <= next_latch; // R01
        end
    end

    // ========================================
    // Direction register
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            port_one_direction <= PIO_RST_REG;
        end else if (wr_dir) begin
            port_one_direction <= hwdata[7:0]; // R01
        end
    end

    // ========================================
    // Function select register
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            port_one_function_select <= PIO_RST_REG;
        end else if (wr_func) begin
            port_one_function_select <= hwdata[7:0]; // R07
        end
    end

    // ========================================
    // Test control register
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            port_one_test_control <= PIO_RST_REG;
        end else if (wr_test) begin
            port_one_test_control <= hwdata[7:0] & PIO_TEST_WMASK; // R16
        end
    end

    // ========================================
    // Buzzer select register
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            input_select_reg <= PIO_RST_REG;
        end else if (wr_select) begin
            input_select_reg <= hwdata[7:0]; // R08
        end
    end

    // ========================================
    // Operand seen by read-modify-write
    assign rmw_operand = port_one_latch; // R06

    // ========================================
    // Read data
    always_comb begin
        next_hrdata = 32'h0000_0000;
        case (rd_idx)
            PIO_ADDR_LATCH: begin
                next_hrdata[7:0] = pin_in; // R05
            end
            PIO_ADDR_DIR: begin
                next_hrdata[7:0] = port_one_direction;
            end
            PIO_ADDR_FUNC: begin
                next_hrdata[7:0] = port_one_function_select;
            end
            PIO_ADDR_TEST: begin
                next_hrdata[7:0] = port_one_test_control;
            end
            PIO_ADDR_SELECT: begin
                next_hrdata[7:0] = input_select_reg;
            end
            PIO_ADDR_RMW: begin
                next_hrdata[7:0] = rmw_operand; // R06
            end
            PIO_ADDR_MODE: begin
                next_hrdata[7:0] = {7'h00, halt_hold};
            end
            default: begin
                next_hrdata = 32'h0000_0000;
            end
        endcase
    end

    // ========================================
    // Read data register
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            hrdata <= 32'h0000_0000;
        end else if (rd_en) begin
            hrdata <= next_hrdata;
        end
    end

    // ========================================
    // Function multiplexer
    always_comb begin
        func_value = port_one_latch;
        func_value[PIO_PIN_PWM_H] = input_select_reg[PIO_BUZ_SEL_BIT]
            ? (port_one_latch[PIO_PIN_PWM_H] ^ buzzer_signal) : timer_high_pwm; // R08
        func_value[PIO_PIN_PWM_L]  = timer_low_pwm ^ port_one_latch[PIO_PIN_PWM_L]; // R09
        func_value[PIO_PIN_S1_CLK] = serial_iface_one_clk | port_one_latch[PIO_PIN_S1_CLK]; // R10
        func_value[PIO_PIN_S1_RX]  = serial_iface_one_txd | port_one_latch[PIO_PIN_S1_RX]; // R11
        func_value[PIO_PIN_S1_TX]  = serial_iface_one_txd | port_one_latch[PIO_PIN_S1_TX]; // R11
        func_value[PIO_PIN_S0_CLK] = serial_iface_zero_clk | port_one_latch[PIO_PIN_S0_CLK]; // R13
        func_value[PIO_PIN_S0_RX]  = serial_iface_zero_txd | port_one_latch[PIO_PIN_S0_RX]; // R14
        func_value[PIO_PIN_S0_TX]  = serial_iface_zero_txd | port_one_latch[PIO_PIN_S0_TX]; // R14
    end

    // ========================================
    // Pin drivers
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi = gi + 1) begin : g_pin
            always_comb begin
                drive_value[gi]  = port_one_function_select[gi] ? func_value[gi] : port_one_latch[gi]; // R07
                next_pin_out[gi] = drive_value[gi]; // R04
            end

            always_comb begin
                if (!port_one_direction[gi]) begin
                    next_pin_oe[gi] = 1'b0; // R02
                end else if (open_drain_sel[gi]) begin
                    next_pin_oe[gi] = !drive_value[gi]; // R19
                end else begin
                    next_pin_oe[gi] = 1'b1; // R04
                end
            end

            always_comb begin
                next_pullup[gi] = !port_one_direction[gi] && port_one_latch[gi]; // R03
            end
        end
    endgenerate

    // ========================================
    // Pin output values, frozen in halt or hold
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pin_out <= PIO_RST_REG;
        end else if (!halt_hold) begin
            pin_out <= next_pin_out; // R18
        end
    end

    // ========================================
    // Pin output enables, frozen in halt or hold
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pin_oe <= PIO_RST_REG;
        end else if (!halt_hold) begin
            pin_oe <= next_pin_oe; // R18
        end
    end

    // ========================================
    // Pin pull-ups, frozen in halt or hold
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pin_pullup <= PIO_RST_REG;
        end else if (!halt_hold) begin
            pin_pullup <= next_pullup; // R18
        end
    end

    // ========================================
    // Serial one receive data
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            serial_iface_one_rxd <= 1'b0;
        end else begin
            serial_iface_one_rxd <= serial_iface_one_active ? pin_in[PIO_PIN_S1_RX] : 1'b0; // R12
        end
    end

    // ========================================
    // Serial zero receive data
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            serial_iface_zero_rxd <= 1'b0;
        end else begin
            serial_iface_zero_rxd <= serial_iface_zero_active ? pin_in[PIO_PIN_S0_RX] : 1'b0; // R15
        end
    end

    // ========================================
    // Realtime counter output control
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            realtime_counter_out_ctrl <= 1'b0;
        end else begin
            realtime_counter_out_ctrl <= port_one_test_control[PIO_RT_OUT_BIT]; // R17
        end
    end

endmodule : pio_port_one

// file: tb/pio_board.sv
`timescale 1ns/100ps
// ========================================
// Board side of the eight pins
module pio_board (
    input  wire logic       clk_sys,
    input  wire logic [7:0] pin_out,
    input  wire logic [7:0] pin_oe,
    input  wire logic [7:0] pin_pullup,
    input  wire logic [7:0] ext_en,
    input  wire logic [7:0] ext_val,
    output logic      [7:0] pin_in
);
    logic [7:0] float_lvl;
    initial float_lvl = 8'h55;
    // Undriven pin without pull-up wanders every cycle
    always @(posedge clk_sys) float_lvl <= ~float_lvl;
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
                  | (~pin_oe & ~ext_en & (pin_pullup | float_lvl));
endmodule : pio_board

// file: tb/pio_port_one_checker.sv
`timescale 1ns/100ps
// ========================================
// Port checker
module pio_port_one_checker (
    input wire logic        clk_sys,
    input wire logic        rst,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic [31:0] hrdata,
    input wire logic [7:0]  pin_in,
    input wire logic [7:0]  pin_out,
    input wire logic [7:0]  pin_oe,
    input wire logic [7:0]  pin_pullup,
    input wire logic [7:0]  open_drain_sel,
    input wire logic        halt_hold,
    input wire logic        serial_iface_one_active,
    input wire logic        serial_iface_zero_active,
    input wire logic        serial_iface_one_rxd,
    input wire logic        serial_iface_zero_rxd
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    sequence s_held;
        halt_hold ##1 halt_hold;
    endsequence
    a_ready_always: assert property (hreadyout) else $error("hreadyout low");
    a_resp_okay: assert property (!hresp) else $error("hresp not okay");
    a_rdata_upper: assert property (hrdata[31:8] == 24'h00_0000) else $error("hrdata upper set");
    a_pullup_input: assert property ((pin_pullup & pin_oe) == 8'h00) else $error("pullup on driven pin");
    a_od_low_only: assert property ($stable(open_drain_sel) |-> (pin_oe & open_drain_sel & pin_out) == 8'h00)
        else $error("open drain driving high");
    a_hold_freeze: assert property (s_held |-> $stable(pin_out) && $stable(pin_oe) && $stable(pin_pullup))
        else $error("pins moved in hold");
    a_rx_one: assert property (serial_iface_one_active |=> serial_iface_one_rxd == $past(pin_in[4]))
        else $error("serial one rx wrong");
    a_rx_zero: assert property (serial_iface_zero_active |=> serial_iface_zero_rxd == $past(pin_in[1]))
        else $error("serial zero rx wrong");
endmodule : pio_port_one_checker

// file: tb/pio_port_one_test.sv
`timescale 1ns/100ps
// ========================================
// Testbench
module pio_port_one_test;
    import pio_pkg::*;
    logic        clk_sys, rst, hsel, hwrite, hreadyout, hresp, halt_hold, bsel;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [7:0]  pin_in, pin_out, pin_oe, pin_pullup, open_drain_sel, ext_en, ext_val, lat, e;
    logic [6:0]  periph;
    logic        serial_iface_one_active, serial_iface_zero_active, serial_iface_one_rxd, serial_iface_zero_rxd;
    logic        realtime_counter_out_ctrl;
    wire logic   hready, timer_high_pwm, timer_low_pwm, buzzer_signal;
    wire logic   serial_iface_one_clk, serial_iface_one_txd, serial_iface_zero_clk, serial_iface_zero_txd;
    int          miscompares, total_checks;
    logic [7:0]  ops [5] = '{8'h10, 8'h71, 8'h02, 8'h03, 8'h04};
    logic [7:0]  rmw_exp [5] = '{8'ha7, 8'h27, 8'h26, 8'h27, 8'h26};
    assign hready = hreadyout;
    assign {timer_high_pwm, timer_low_pwm, buzzer_signal, serial_iface_one_clk,
            serial_iface_one_txd, serial_iface_zero_clk, serial_iface_zero_txd} = periph;
    pio_port_one DUT (.*);
    pio_board u_board (.clk_sys, .pin_out, .pin_oe, .pin_pullup, .ext_en, .ext_val, .pin_in);
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    // ========================================
    // Bus and compare tasks
    task automatic give_verdict();
        $display("checks=%0d mismatches=%0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : give_verdict
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic wait_rdy();
        int n;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (hreadyout !== 1'b1 && n < 64);
        if (hreadyout !== 1'b1) begin
            miscompares++;
            give_verdict();
        end
    endtask : wait_rdy
    task automatic xfer(input logic [15:0] idx, input logic w, input logic [7:0] wd);
        hsel <= 1'b1;
        haddr <= {14'h0, idx, 2'b00};
        hwrite <= w;
        htrans <= PIO_HTRANS_NONSEQ;
        wait_rdy();
        htrans <= 2'b00;
        hwdata <= {24'h0, wd};
        wait_rdy();
        rd = hrdata;
    endtask : xfer
    task automatic wr(input logic [15:0] idx, input logic [7:0] wd);
        xfer(idx, 1'b1, wd);
    endtask : wr
    task automatic rdchk(input logic [15:0] idx, input logic [7:0] exp);
        xfer(idx, 1'b0, 8'h00);
        check(rd, {24'h0, exp});
    endtask : rdchk
    task automatic settle();
        repeat (2) @(posedge clk_sys);
    endtask : settle
    // ========================================
    // Scenarios
    initial begin
        {hsel, hwrite, halt_hold, serial_iface_one_active, serial_iface_zero_active} = 5'b00000;
        haddr = 32'h0000_0000;
        hwdata = 32'h0000_0000;
        htrans = 2'b00;
        hsize = 3'b010;
        {open_drain_sel, periph, ext_en, ext_val} = {8'h00, 7'h00, 8'hff, 8'h5a};
        {miscompares, total_checks} = 0;
        rst = 1'b1;
        repeat (10) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        rdchk(PIO_ADDR_DIR, 8'h00);
        rdchk(PIO_ADDR_FUNC, 8'h00);
        rdchk(PIO_ADDR_LATCH, 8'h5a);
        wr(PIO_ADDR_LATCH, 8'ha5);
        wr(PIO_ADDR_DIR, 8'h0f);
        {ext_en, ext_val, open_drain_sel} <= {8'hf0, 8'h30, 8'h03};
        settle();
        check({pin_oe, pin_pullup, pin_out & 8'h0e}, 24'h0e_a004);
        open_drain_sel <= 8'h00;
        settle();
        rdchk(PIO_ADDR_DIR, 8'h0f);
        rdchk(PIO_ADDR_LATCH, 8'h35);
        for (int k = 0; k < 5; k++) begin
            wr(PIO_ADDR_RMW, ops[k]);
            settle();
            check({pin_pullup[7:4], pin_out[3:0]}, rmw_exp[k]);
        end
        wr(PIO_ADDR_DIR, 8'hff);
        wr(PIO_ADDR_FUNC, 8'hff);
        ext_en <= 8'h00;
        for (int k = 0; k < 8; k++) begin
            lat = k[0] ? 8'hc9 : 8'h00;
            bsel = k[1];
            wr(PIO_ADDR_LATCH, lat);
            wr(PIO_ADDR_SELECT, {4'h0, bsel, 3'b000});
            periph <= k[2] ? 7'h55 : 7'h2a;
            settle();
            e = {bsel ? lat[7] ^ periph[4] : periph[6], periph[5] ^ lat[6], periph[3] | lat[5], periph[2] | lat[4],
                 periph[2] | lat[3], periph[1] | lat[2], periph[0] | lat[1], periph[0] | lat[0]};
            check({pin_oe, pin_out}, {8'hff, e});
        end
        wr(PIO_ADDR_FUNC, 8'h00);
        {serial_iface_one_active, serial_iface_zero_active} <= 2'b11;
        for (int k = 0; k < 2; k++) begin
            lat = k[0] ? 8'h10 : 8'h02;
            wr(PIO_ADDR_LATCH, lat);
            repeat (2) settle();
            check({serial_iface_one_rxd, serial_iface_zero_rxd}, {lat[4], lat[1]});
        end
        wr(PIO_ADDR_TEST, 8'h04);
        settle();
        check(realtime_counter_out_ctrl, 1'b1);
        rdchk(PIO_ADDR_TEST, 8'h04);
        wr(PIO_ADDR_LATCH, 8'h0f);
        settle();
        halt_hold <= 1'b1;
        wr(PIO_ADDR_LATCH, 8'hf0);
        wr(PIO_ADDR_DIR, 8'h00);
        settle();
        check({pin_out, pin_oe, pin_pullup}, 24'h0f_ff00);
        rdchk(PIO_ADDR_LATCH, 8'h0f);
        rdchk(PIO_ADDR_RMW, 8'hf0);
        rdchk(PIO_ADDR_MODE, 8'h01);
        halt_hold <= 1'b0;
        settle();
        check({pin_oe, pin_pullup}, 16'h00f0);
        rdchk(16'hfe50, 8'h00);
        give_verdict();
    end
endmodule : pio_port_one_test
bind pio_port_one pio_port_one_checker u_chk (.*);
